//--- verilog/dep_regs.svh
// constants for the edge-byte pwm output port
`ifndef DEP_REGS_SVH
`define DEP_REGS_SVH
`define DEP_PORT_ADDR     16'h4100
`define DEP_NUM_OUTPUTS   7
`define DEP_NOOP_BYTE     8'h0E
`define DEP_OUT_RESET     7'h00
`define DEP_BASE_RATE_HZ  19200
`define DEP_CLK_HZ        25000000
`define DEP_DEF_CHANNELS  4
`define DEP_DEF_RES       256
`define DEP_DEF_MULT      4
`define DEP_FIFO_DEPTH    16
`endif

//--- verilog/dep_pkg.sv
// types shared by both ends of the edge-byte port
package dep_pkg;
  typedef logic [7:0]  dep_byte_t;
  typedef logic [15:0] dep_addr_t;
  typedef enum logic [1:0] {DEP_IDLE, DEP_RUN, DEP_STOP} dep_state_e;
endpackage

//--- verilog/dep_link_if.sv
// link between host dma end and output port end
interface dep_link_if;
  logic        dma_request_line;
  logic [15:0] io_addr;
  logic [7:0]  io_data;
  logic        io_wr;
  modport host (output dma_request_line, output io_addr, output io_data, output io_wr);
  modport port (input dma_request_line, input io_addr, input io_data, input io_wr);
endinterface

//--- verilog/dep_fifo.sv
// small synchronous fifo with valid/ready on both sides
`include "dep_regs.svh"
module dep_fifo
  import dep_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = `DEP_FIFO_DEPTH
)
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count  = count;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count  <= next_count;
    end
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

//--- verilog/dep_host.sv
// host end: pattern buffer, serial clock pacing, dma byte delivery
`include "dep_regs.svh"
// -----------------------------------------------------------------
// overview list and tags
// -----------------------------------------------------------------
// Overview of operation
// - port takes edge bytes at one address
// - low nibble selects one of outputs 0..6
// - bit zero one drives on, zero off
// - bits three to one carry output number
// - byte 0x0E changes nothing
// - host sends one byte per channel, fixed order
// - strobe rate = channels x frequency x resolution
// - default four channels, 256 divisions, 76800 Hz
// - period is resolution transitions, then restart
// - duty set by edge position in period
// - one transfer per request-line falling edge
// - serial clock at 2, 4 or 8 x 19.2k
// - host rewinds count and source before zero
module dep_host
  import dep_pkg::*;
#(
  parameter int CHANNELS = `DEP_DEF_CHANNELS,
  parameter int RES      = `DEP_DEF_RES,
  parameter int MULT     = `DEP_DEF_MULT,
  parameter int LEN      = CHANNELS * RES
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        run,
  input  wire logic        wb_we,
  input  wire logic [15:0] wb_addr,
  input  wire logic [7:0]  wb_data,
  output logic             running,
  dep_link_if.host         link
);
  // -----------------------------------------------------------------
  // timing and storage
  // -----------------------------------------------------------------
  // defaults give 4 x 256 x 75 Hz = 76800 Hz strobe
  // half period of the request line, multiple of 19.2k
  // the divide truncates, so the strobe runs slightly fast of nominal
  localparam int STROBE_HZ = `DEP_BASE_RATE_HZ * MULT;
  localparam int HALF_CYC  = `DEP_CLK_HZ / (2 * STROBE_HZ);
  localparam int AW        = $clog2(LEN);

  logic [15:0]   div_cnt;
  logic [15:0]   next_div_cnt;
  logic          sclk;
  logic          next_sclk;
  logic          fall;
  logic [AW-1:0] src;
  logic [AW-1:0] next_src;
  dep_state_e    state;
  dep_state_e    next_state;
  logic [7:0]    pattern_mem [LEN];
  logic          next_running;
  logic          next_req;
  logic          next_io_wr;
  logic [15:0]   next_io_addr;
  logic [7:0]    next_io_data;

  // -----------------------------------------------------------------
  // serial clock divider
  // -----------------------------------------------------------------
  // fall marks the edge that launches one transfer
  assign fall = (div_cnt == 16'(HALF_CYC - 1)) && sclk && (state == DEP_RUN);

  always_comb
  begin
    next_div_cnt = div_cnt + 16'h0001;
    next_sclk    = sclk;
    if (state != DEP_RUN)
    begin
      next_div_cnt = 16'h0000;
      next_sclk    = 1'b1;
    end
    else if (div_cnt == 16'(HALF_CYC - 1))
    begin
      next_div_cnt = 16'h0000;
      next_sclk    = !sclk;
    end
  end

  // -----------------------------------------------------------------
  // dma source walk
  // -----------------------------------------------------------------
  // rewinding the source at the end keeps the waveform seamless
  always_comb
  begin
    next_src   = src;
    next_state = state;
    unique case (state)
      DEP_IDLE:
      begin
        next_src = '0;
        if (run)
        begin
          next_state = DEP_RUN;
        end
      end
      DEP_RUN:
      begin
        if (fall)
        begin
          next_src = (src == AW'(LEN - 1)) ? '0 : src + 1'b1;
        end
        if (!run)
        begin
          next_state = DEP_STOP;
        end
      end
      DEP_STOP:
      begin
        // divider is cleared here, so the line is back high before idle
        next_state = DEP_IDLE;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // link drive
  // -----------------------------------------------------------------
  // address and data only move on a strobe, so the port may sample late
  // the strobe rides the same edge as the request line falling
  always_comb
  begin
    next_running = (next_state == DEP_RUN);
    next_req     = next_sclk;
    next_io_wr   = fall;
    next_io_addr = link.io_addr;
    next_io_data = link.io_data;
    if (fall)
    begin
      next_io_addr = `DEP_PORT_ADDR;
      next_io_data = pattern_mem[src];
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  // divider held at idle so the request line stays high between runs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_cnt <= 16'h0000;
      sclk    <= 1'b1;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      sclk    <= next_sclk;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      src   <= '0;
      state <= DEP_IDLE;
    end
    else
    begin
      src   <= next_src;
      state <= next_state;
    end
  end

  // link resets to a no-op byte so a stray strobe changes nothing; after a run it holds the last byte sent
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      running               <= 1'b0;
      link.dma_request_line <= 1'b1;
      link.io_addr          <= 16'h0000;
      link.io_data          <= `DEP_NOOP_BYTE;
      link.io_wr            <= 1'b0;
    end
    else
    begin
      running               <= next_running;
      link.dma_request_line <= next_req;
      link.io_addr          <= next_io_addr;
      link.io_data          <= next_io_data;
      link.io_wr            <= next_io_wr;
    end
  end

  // -----------------------------------------------------------------
  // pattern buffer
  // -----------------------------------------------------------------
  // pattern written by software; edge positions set duty
  // no reset on the pattern: it must be loaded before run is raised
  always_ff @(posedge clk)
  begin
    if (wb_we && (32'(wb_addr) < LEN))
    begin
      pattern_mem[wb_addr[AW-1:0]] <= wb_data;
    end
  end
endmodule

//--- verilog/dep_port.sv
// device end: edge-byte output latch for seven high-current outputs
`include "dep_regs.svh"
module dep_port
  import dep_pkg::*;
#(
  parameter int NOUT = `DEP_NUM_OUTPUTS
)
(
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            drain_ready,
  output logic      [NOUT-1:0] hc_out,
  output logic                 overflow,
  dep_link_if.port             link
);
  // -----------------------------------------------------------------
  // capture and buffer
  // -----------------------------------------------------------------
  logic [7:0]      wr_s1;
  logic [7:0]      wr_s2;
  logic            wr_q1;
  logic            wr_q2;
  logic            wr_q3;
  logic [15:0]     ad_s1;
  logic [15:0]     ad_s2;
  logic            hit;
  logic            in_ready;
  logic [7:0]      f_data;
  logic            f_valid;
  logic [NOUT-1:0] next_hc_out;
  logic [2:0]      sel;
  logic            next_overflow;

  // data and address pass two flops, the strobe three; data moves with the strobe and the edge is taken at the second stage, level with it
  always_ff @(posedge clk)
  begin
    wr_s1 <= link.io_data;
    wr_s2 <= wr_s1;
    ad_s1 <= link.io_addr;
    ad_s2 <= ad_s1;
    wr_q1 <= link.io_wr;
    wr_q2 <= wr_q1;
    wr_q3 <= wr_q2;
  end

  assign hit = wr_q2 && !wr_q3 && (ad_s2 == `DEP_PORT_ADDR);

  dep_fifo #(.WIDTH(8), .DEPTH(`DEP_FIFO_DEPTH)) u_dep_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_data   (wr_s2),
    .in_valid  (hit),
    .in_ready  (in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (drain_ready)
  );

  // -----------------------------------------------------------------
  // edge decode
  // -----------------------------------------------------------------
  assign sel = f_data[3:1];
  always_comb
  begin
    next_hc_out   = hc_out;
    next_overflow = overflow || (hit && !in_ready); // sticky; no host stall exists
    // 0x0E selects no output, so nothing moves
    if (f_valid && drain_ready && (32'(sel) < NOUT))
    begin
      next_hc_out[sel] = f_data[0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hc_out   <= `DEP_OUT_RESET;
      overflow <= 1'b0;
    end
    else
    begin
      hc_out   <= next_hc_out;
      overflow <= next_overflow;
    end
  end
endmodule

//--- testbench/dep_link_properties.sv
// link timing checks between host end and port end
module dep_link_properties
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        dma_request_line,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_data,
  input wire logic        io_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // -----------------------------------------------
  // properties
  // -----------------------------------------------
  property p_addr; io_wr |-> io_addr == 16'h4100; endproperty
  a_addr: assert property (p_addr)
    else $error("strobe off the port address");
  property p_pulse; io_wr |=> !io_wr [*8]; endproperty
  a_pulse: assert property (p_pulse)
    else $error("strobe too long or too close");
  property p_low; io_wr |-> !dma_request_line; endproperty
  a_low: assert property (p_low)
    else $error("strobe outside low phase");
  property p_fall; $fell(dma_request_line) |-> ##[0:2] io_wr; endproperty
  a_fall: assert property (p_fall)
    else $error("no transfer after request fell");
  property p_hold; $changed(io_data) |-> io_wr; endproperty
  a_hold: assert property (p_hold)
    else $error("data moved between strobes");
  property p_half; $rose(dma_request_line) |=> dma_request_line [*8]; endproperty
  a_half: assert property (p_half)
    else $error("request high phase too short");
  // low phase bounded both ways; run only stops through reset
  property p_period;
    $fell(dma_request_line) |=> !dma_request_line [*8] ##[1:400] dma_request_line;
  endproperty
  a_period: assert property (p_period)
    else $error("request low phase out of range");
  property p_rst; $past(srst) |-> dma_request_line && !io_wr && io_data == 8'h0E; endproperty
  a_rst: assert property (p_rst)
    else $error("link not idle after reset");
  c_fall: cover property ($fell(dma_request_line));
  c_noop: cover property (io_wr && io_data == 8'h0E);
  c_on: cover property (io_wr && io_data[0]);
endmodule

//--- testbench/dma_edge_pwm_output_port_bench.sv
// self-checking bench joining host end and port end
module dma_edge_pwm_output_port_bench import dep_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, srst = 1, run = 0, wb_we = 0, drain_ready = 1;
  logic [15:0] wb_addr = 16'h0000;
  dep_byte_t   wb_data = 8'h00;
  logic        running, overflow;
  logic [6:0]  hc_out, model;
  int          err_count = 0, total_checks = 0, cycles = 0;
  dep_byte_t   pat [16];
  dep_link_if  link ();
  // small pattern keeps periods short
  dep_host #(.CHANNELS(2), .RES(8), .MULT(8)) u_dep_host (.clk(clk), .srst(srst),
    .run(run), .wb_we(wb_we), .wb_addr(wb_addr), .wb_data(wb_data),
    .running(running), .link(link.host));
  dep_port u_dep_port (.clk(clk), .srst(srst), .drain_ready(drain_ready),
    .hc_out(hc_out), .overflow(overflow), .link(link.port));
  dep_link_properties u_props (.clk(clk), .srst(srst),
    .dma_request_line(link.dma_request_line), .io_addr(link.io_addr),
    .io_data(link.io_data), .io_wr(link.io_wr));
  // -----------------------------------------------
  // tasks
  // -----------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic do_reset;
    srst = 1;
    run = 0;
    model = 7'h00;
    repeat (4) @(negedge clk);
    srst = 0;
  endtask
  // strobe held high across the burst, dropped once
  task automatic load;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clk);
      wb_we = 1;
      wb_addr = 16'(i);
      wb_data = pat[i];
    end
    @(negedge clk);
    wb_we = 0;
  endtask
  task automatic go(input int a, input int b);
    int n;
    @(negedge clk);
    run = 1;
    for (int k = a; k < b; k++)
    begin
      n = 0;
      while (link.io_wr !== 1'b1 && n < 400)
      begin
        @(negedge clk);
        n++;
      end
      check("strobe", {7'h00, link.io_wr}, 8'h01);
      check("byte", link.io_data, pat[k % 16]);
      check("running", {7'h00, running}, 8'h01);
      repeat (6) @(negedge clk);
      // stalled consumer: byte sits in fifo, outputs frozen
      if (drain_ready && pat[k % 16][3:1] != 3'h7)
        model[pat[k % 16][3:1]] = pat[k % 16][0];
      check("outputs", {1'b0, hc_out}, {1'b0, model});
    end
  endtask
  // -----------------------------------------------
  // sequence
  // -----------------------------------------------
  initial
    forever #20 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      err_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    pat = '{8'h01, 8'h03, 8'h0E, 8'h0E, 8'h0E, 8'h0E, 8'h00, 8'h0E,
            8'h0E, 8'h0E, 8'h0E, 8'h0E, 8'h0E, 8'h02, 8'h0E, 8'h0E};
    do_reset;
    check("reset out", {1'b0, hc_out}, 8'h00);
    check("reset ovf", {7'h00, overflow}, 8'h00);
    check("reset run", {7'h00, running}, 8'h00);
    load;
    go(0, 40);
    // every on and off code, selector 7 included
    pat = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0B, 8'h0D, 8'h0F,
            8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E};
    do_reset;
    load;
    go(0, 32);
    do_reset;
    drain_ready = 0;
    go(0, 17);
    check("overflow", {7'h00, overflow}, 8'h01);
    drain_ready = 1;
    go(17, 21);
    check("sticky", {7'h00, overflow}, 8'h01);
    tally_and_finish;
  end
endmodule
